// ### rps_dip_detect.sv
// Purpose: qualifies a low-supply indication against the minimum dip duration
// Assumes: detector input asynchronous, high while supply below threshold
// Notes:   dips shorter than the minimum are dropped
`timescale 1ns/1ps
module rps_dip_detect
  import rps_pkg::*;
#(
  parameter int unsigned DIP_CYCLES = DIP_MIN_CYCLES
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // detector
  input  wire logic below_threshold,
  input  wire logic dip_enable,
  output logic      dip_low,
  output logic      dip_reset
);
  logic        s1_reg, s2_reg;
  logic [15:0] cnt_reg, cnt_next;
  logic        hold_reg, hold_next;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= below_threshold;
      s2_reg <= s1_reg;
    end
  end

  always_comb begin
    cnt_next  = 16'h0000;
    hold_next = hold_reg && s2_reg && dip_enable;
    if (s2_reg && dip_enable) begin
      cnt_next = cnt_reg + 16'h0001;
      if (cnt_reg >= 16'(DIP_CYCLES - 1)) begin
        cnt_next  = cnt_reg;
        hold_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= 16'h0000;
      hold_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      hold_reg <= hold_next;
    end
  end

  // once qualified, reset holds while supply stays low
  assign dip_reset = hold_reg;
  assign dip_low   = s2_reg && dip_enable;
endmodule

// ### rps_far_side.sv
// Purpose: model of the pin, supply detectors, watchdog and crystal
// Assumes: pin idles high through its pull-up
// Notes:   crystal runs free, unrelated in phase to pclk
`timescale 1ns/1ps
module rps_far_side (
  // clock
  input  wire logic pclk,
  // lines into the sequencer
  output logic      supply_rise,
  output logic      external_reset_pin_n,
  output logic      below_threshold,
  output logic      watchdog_timeout,
  output logic      oscillator_input
);
  initial begin
    supply_rise = 1'b0;
    external_reset_pin_n = 1'b1;
    below_threshold = 1'b0;
    watchdog_timeout = 1'b0;
    oscillator_input = 1'b0;
  end
  always #17 oscillator_input = ~oscillator_input;
  task automatic rise_pulse();
    @(posedge pclk) supply_rise <= 1'b1;
    repeat (2) @(posedge pclk);
    supply_rise <= 1'b0;
  endtask
  // held low for n cycles, then back to the pull-up level
  task automatic pin_low(input int n);
    @(posedge pclk) external_reset_pin_n <= 1'b0;
    repeat (n) @(posedge pclk);
    external_reset_pin_n <= 1'b1;
  endtask
  task automatic wdog();
    @(posedge pclk) watchdog_timeout <= 1'b1;
    repeat (3) @(posedge pclk);
    watchdog_timeout <= 1'b0;
  endtask
  task automatic dip(input int n);
    @(posedge pclk) below_threshold <= 1'b1;
    repeat (n) @(posedge pclk);
    below_threshold <= 1'b0;
  endtask
endmodule

// ### rps_pkg.sv
// Purpose: shared constants and types for the reset and start-up sequencer
// Assumes: pclk at 100 MHz
// Notes:   register map is reached over APB, one 32-bit word per register
package rps_pkg;

  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned SETTLE_DELAY_MS  = 72;
  localparam int unsigned SETTLE_CYCLES    = SETTLE_DELAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned DIP_MIN_US       = 100;
  localparam int unsigned DIP_MIN_CYCLES   = DIP_MIN_US * CLK_MHZ;
  localparam int unsigned OSC_SETTLE_COUNT = 1024;
  localparam int unsigned PIN_FILTER_CYC   = 8;

  localparam logic [15:0] IRQ_VECTOR       = 16'h0004;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;

  localparam logic [7:0] OFS_CFG           = 8'h00;
  localparam logic [7:0] OFS_STATUS        = 8'h04;
  localparam logic [7:0] OFS_KEEP          = 8'h08;
  localparam logic [7:0] OFS_SCRATCH       = 8'h0C;

  localparam int unsigned CFG_SETTLE_EN    = 0;
  localparam int unsigned CFG_DIP_EN       = 1;
  localparam int unsigned CFG_OSC_LSB      = 2;
  localparam logic [3:0]  CFG_RESET        = 4'h3;
  localparam logic [31:0] SCRATCH_RESET    = 32'h0000_0000;

  typedef enum logic [1:0] {
    OSC_RC, OSC_LOWFREQ, OSC_CRYSTAL, OSC_FAST
  } rps_osc_mode_t;

  typedef enum logic [2:0] {
    KIND_NONE, KIND_SUPPLY_RISE, KIND_PIN_RUN, KIND_PIN_SLEEP,
    KIND_WDOG_RUN, KIND_WDOG_WAKE, KIND_SUPPLY_DIP
  } rps_kind_t;

  typedef struct packed {
    logic watchdog_expiry_flag;
    logic sleep_entered_flag;
  } rps_flags_t;

  typedef struct packed {
    logic        core_reset;
    logic        wake;
    logic        vector_irq;
    rps_kind_t   kind;
  } rps_core_ctl_t;

endpackage

// ### rps_sequencer.sv
// Purpose: merges reset sources, runs settle delays, keeps cause flags
// Assumes: detectors and watchdog are separate; osc input sampled on pclk
// Notes:   settle delay is counted on pclk standing in for the RC clock
//
// Function
// - classify six reset kinds and report the latest one
// - keep-group register never loaded by any reset
// - ordinary registers reset on all kinds except watchdog wake-up
// - update expiry and sleep flags per reset kind
// - filter external pin so short pulses are ignored
// - watchdog reset acts internally, never drives the pin
// - supply-rise detector starts a supply-rise reset
// - settle timer gives fixed 72 ms delay, from supply-rise
// - chip held in reset while settle timer runs
// - config bit selects whether settle timer is used
// - after settle, count 1024 oscillator input cycles
// - oscillator count only in crystal modes, after supply-rise or wake
// - dip enable bit switches dip reset on or off
// - supply below threshold longer than minimum causes reset
// - stay in reset until supply recovers, then settle delay
// - new dip during settle restarts process and timer
// - dip enable forces settle timer on
// - settle first, then oscillator count, then release
// - pin held low past delays releases execution at once; a pin low during settle or oscillator count pauses those timers instead
// - interrupt wake with global enable loads interrupt vector
// - sleep flag set on power-up, cleared by sleep
// - expiry flag cleared on watchdog time-out
`timescale 1ns/1ps
module rps_sequencer
  import rps_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = SETTLE_CYCLES
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // reset sources
  input  wire logic        supply_rise,
  input  wire logic        external_reset_pin_n,
  input  wire logic        below_threshold,
  input  wire logic        watchdog_timeout,
  // core events
  input  wire logic        sleep_exec,
  input  wire logic        irq_wake,
  input  wire logic        global_irq_enable,
  input  wire logic        oscillator_input,
  // outputs to chip
  output logic             core_reset_n,
  output logic             regs_reset_n,
  output logic             wake_pulse,
  output logic [15:0]      start_vector,
  output rps_flags_t       flags,
  output rps_kind_t        reset_kind,
  output logic             external_reset_pin_oe
);
  typedef enum logic [2:0] {
    ST_SETTLE, ST_OSC, ST_HOLD, ST_RUN, ST_SLEEP
  } rps_state_t;

  function automatic logic osc_needs_count(input logic [1:0] m);
    return (m != 2'(OSC_RC));
  endfunction

  logic pin_reset, dip_reset, dip_low;
  logic [3:0]  cfg_reg, cfg_next;
  logic por_s1_reg, por_s2_reg, wd_s1_reg, wd_s2_reg, osc_s1_reg, osc_s2_reg, osc_s3_reg;
  logic irq_s1_reg, irq_s2_reg;

  rps_sync_filter u_filter (
    .pclk                 (pclk),
    .presetn              (presetn),
    .external_reset_pin_n (external_reset_pin_n),
    .pin_reset            (pin_reset)
  );

  rps_dip_detect u_dip (
    .pclk            (pclk),
    .presetn         (presetn),
    .below_threshold (below_threshold),
    .dip_enable      (cfg_reg[CFG_DIP_EN]),
    .dip_low         (dip_low),
    .dip_reset       (dip_reset)
  );

  // analogue and foreign-domain levels pass two flops first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_s1_reg <= 1'b0;
      por_s2_reg <= 1'b0;
      wd_s1_reg  <= 1'b0;
      wd_s2_reg  <= 1'b0;
      irq_s1_reg <= 1'b0;
      irq_s2_reg <= 1'b0;
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end else begin
      por_s1_reg <= supply_rise;
      por_s2_reg <= por_s1_reg;
      wd_s1_reg  <= watchdog_timeout;
      wd_s2_reg  <= wd_s1_reg;
      irq_s1_reg <= irq_wake;
      irq_s2_reg <= irq_s1_reg;
      osc_s1_reg <= oscillator_input;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end

  logic osc_rise;
  assign osc_rise = osc_s2_reg && !osc_s3_reg;

  logic        wd_prev_reg;
  logic        wd_event;
  assign wd_event = wd_s2_reg && !wd_prev_reg;

  rps_state_t  state_reg, state_next;
  logic [31:0] settle_reg, settle_next;
  logic [10:0] osc_cnt_reg, osc_cnt_next;
  rps_kind_t   kind_reg, kind_next;
  rps_flags_t  flags_reg, flags_next;
  logic        regs_rst_reg, regs_rst_next;
  logic        wake_reg, wake_next;
  logic [15:0] vec_reg, vec_next;
  logic [31:0] scratch_reg, scratch_next;
  logic [31:0] keep_reg, keep_next;
  logic        settle_en;

  assign settle_en = cfg_reg[CFG_SETTLE_EN] || cfg_reg[CFG_DIP_EN];

  always_comb begin
    state_next    = state_reg;
    settle_next   = settle_reg;
    osc_cnt_next  = osc_cnt_reg;
    kind_next     = kind_reg;
    flags_next    = flags_reg;
    regs_rst_next = 1'b0;
    wake_next     = 1'b0;
    vec_next      = vec_reg;
    if (por_s2_reg) begin
      state_next    = ST_SETTLE;
      settle_next   = 32'h0000_0000;
      osc_cnt_next  = 11'h000;
      kind_next     = KIND_SUPPLY_RISE;
      flags_next    = '{watchdog_expiry_flag: 1'b1, sleep_entered_flag: 1'b1};
      regs_rst_next = 1'b1;
      vec_next      = RESET_VECTOR;
    end else if (dip_low) begin
      // restart settle while supply is low again
      if (dip_reset || state_reg == ST_SETTLE) begin
        state_next    = ST_SETTLE;
        settle_next   = 32'h0000_0000;
        osc_cnt_next  = 11'h000;
        regs_rst_next = 1'b1;
        if (dip_reset) begin
          kind_next  = KIND_SUPPLY_DIP;
          flags_next = '{watchdog_expiry_flag: 1'b1, sleep_entered_flag: 1'b1};
          vec_next   = RESET_VECTOR;
        end
      end
    end else if (pin_reset) begin
      // pin low holds the core; settle and oscillator timers pause underneath
      if (state_reg == ST_RUN || state_reg == ST_SLEEP) begin
        kind_next  = (state_reg == ST_SLEEP) ? KIND_PIN_SLEEP : KIND_PIN_RUN;
        flags_next.sleep_entered_flag = (state_reg != ST_SLEEP);
        vec_next   = RESET_VECTOR;
        state_next = ST_HOLD;
      end
      regs_rst_next = 1'b1;
    end
    if (!por_s2_reg && !dip_low && !pin_reset) begin
      unique case (state_reg)
        ST_SETTLE: begin
          if (!settle_en || settle_reg >= SETTLE_CYC - 1) begin
            state_next = (kind_reg == KIND_SUPPLY_RISE && osc_needs_count(cfg_reg[3:2])) ? ST_OSC : ST_RUN;
          end else begin
            settle_next = settle_reg + 32'h0000_0001;
          end
        end
        ST_OSC: begin
          if (osc_rise) begin
            osc_cnt_next = osc_cnt_reg + 11'h001;
          end
          if (osc_cnt_reg == 11'(OSC_SETTLE_COUNT)) begin
            state_next = ST_RUN;
            wake_next  = (kind_reg == KIND_WDOG_WAKE) || (kind_reg == KIND_NONE);
          end
        end
        ST_HOLD: begin
          // pin released: delays already past, run at once
          state_next = ST_RUN;
        end
        ST_RUN: begin
          if (wd_event) begin
            kind_next     = KIND_WDOG_RUN;
            flags_next    = '{watchdog_expiry_flag: 1'b0, sleep_entered_flag: 1'b1};
            regs_rst_next = 1'b1;
            vec_next      = RESET_VECTOR;
          end else if (sleep_exec) begin
            state_next    = ST_SLEEP;
            flags_next    = '{watchdog_expiry_flag: 1'b1, sleep_entered_flag: 1'b0};
          end
        end
        ST_SLEEP: begin
          if (wd_event || irq_s2_reg) begin
            kind_next = wd_event ? KIND_WDOG_WAKE : KIND_NONE;
            if (wd_event) begin
              flags_next.watchdog_expiry_flag = 1'b0;
            end
            vec_next = (!wd_event && global_irq_enable) ? IRQ_VECTOR : vec_reg;
            osc_cnt_next = 11'h000;
            // wake never reloads ordinary registers
            state_next = osc_needs_count(cfg_reg[3:2]) ? ST_OSC : ST_RUN;
            wake_next  = !osc_needs_count(cfg_reg[3:2]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_SETTLE;
      settle_reg   <= 32'h0000_0000;
      osc_cnt_reg  <= 11'h000;
      kind_reg     <= KIND_SUPPLY_RISE;
      flags_reg    <= '{watchdog_expiry_flag: 1'b1, sleep_entered_flag: 1'b1};
      regs_rst_reg <= 1'b1;
      wake_reg     <= 1'b0;
      vec_reg      <= RESET_VECTOR;
      wd_prev_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      settle_reg   <= settle_next;
      osc_cnt_reg  <= osc_cnt_next;
      kind_reg     <= kind_next;
      flags_reg    <= flags_next;
      regs_rst_reg <= regs_rst_next;
      wake_reg     <= wake_next;
      vec_reg      <= vec_next;
      wd_prev_reg  <= wd_s2_reg;
    end
  end

  // apb: zero wait states, unmapped offsets error
  logic wr_en, acc, mapped;
  assign acc    = psel && penable;
  assign wr_en  = acc && pwrite;
  assign mapped = (paddr == OFS_CFG) || (paddr == OFS_STATUS) || (paddr == OFS_KEEP) || (paddr == OFS_SCRATCH);

  always_comb begin
    cfg_next     = cfg_reg;
    scratch_next = scratch_reg;
    keep_next    = keep_reg;
    if (wr_en && paddr == OFS_CFG) cfg_next = pwdata[3:0];
    if (wr_en && paddr == OFS_SCRATCH) scratch_next = pwdata;
    if (wr_en && paddr == OFS_KEEP) keep_next = pwdata;
    if (regs_rst_reg) scratch_next = SCRATCH_RESET;
  end

  // config straps hold across internal resets; only presetn loads them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg     <= CFG_RESET;
      scratch_reg <= SCRATCH_RESET;
    end else begin
      cfg_reg     <= cfg_next;
      scratch_reg <= scratch_next;
    end
  end

  // keep group has no reset at all
  always_ff @(posedge pclk) begin
    keep_reg <= keep_next;
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (acc && !pwrite) begin
      unique case (paddr)
        OFS_CFG:     prdata = {28'h0000000, cfg_reg};
        OFS_STATUS:  prdata = {23'h000000, state_reg, kind_reg, flags_reg, 1'b0};
        OFS_KEEP:    prdata = keep_reg;
        OFS_SCRATCH: prdata = scratch_reg;
        default:     prdata = 32'h0000_0000;
      endcase
    end
  end

  assign pready                = 1'b1;
  assign pslverr               = acc && !mapped;
  assign core_reset_n          = (state_reg == ST_RUN) || (state_reg == ST_SLEEP);
  assign regs_reset_n          = !regs_rst_reg;
  assign wake_pulse            = wake_reg;
  assign start_vector          = vec_reg;
  assign flags                 = flags_reg;
  assign reset_kind            = kind_reg;
  assign external_reset_pin_oe = 1'b0;
endmodule

// ### rps_sequencer_assertions.sv
// Purpose: port-level checks of the reset and start-up sequencer
// Assumes: bound to rps_sequencer, one clock domain
// Notes:   settle length counted from reset release or supply rise
`timescale 1ns/1ps
module rps_sequencer_assertions
  import rps_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = 50
) (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // sources and outputs
  input wire logic        supply_rise,
  input wire logic        watchdog_timeout,
  input wire logic        core_reset_n,
  input wire logic        regs_reset_n,
  input wire logic        wake_pulse,
  input wire logic        external_reset_pin_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] since_reg;
  logic [31:0] since_next;
  logic        acc;
  logic        mapped;
  assign acc    = psel && penable;
  assign mapped = paddr inside {OFS_CFG, OFS_STATUS, OFS_KEEP, OFS_SCRATCH};
  // saturates so a long run never wraps into a false short count
  always_comb begin
    since_next = supply_rise ? 32'h0 : since_reg + {31'h0, since_reg != 32'hFFFF_FFFF};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_reg <= 32'h0;
    else since_reg <= since_next;
  end
  a_pin_never_driven: assert property (external_reset_pin_oe == 1'b0) else $error("pin driven");
  a_ready_no_wait: assert property (acc |-> pready) else $error("pready late");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr) else $error("no slave error");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("false slave error");
  a_rdata_idle: assert property (!acc |-> prdata == 32'h0) else $error("prdata outside access");
  a_rise_resets: assert property ($rose(supply_rise) |-> ##[1:5] !core_reset_n) else $error("rise ignored");
  a_settle_len: assert property ($rose(core_reset_n) |-> since_reg >= SETTLE_CYC) else $error("settle short");
  a_wdog_internal: assert property ($rose(watchdog_timeout) && core_reset_n |=> core_reset_n [*6])
    else $error("core reset by watchdog");
  a_wake_no_reload: assert property (wake_pulse |-> regs_reset_n) else $error("wake reloaded regs");
  a_wake_single: assert property (wake_pulse |=> !wake_pulse) else $error("wake pulse long");
endmodule
bind rps_sequencer rps_sequencer_assertions #(.SETTLE_CYC(SETTLE_CYC)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .supply_rise(supply_rise), .watchdog_timeout(watchdog_timeout),
  .core_reset_n(core_reset_n), .regs_reset_n(regs_reset_n), .wake_pulse(wake_pulse),
  .external_reset_pin_oe(external_reset_pin_oe));

// ### rps_sync_filter.sv
// Purpose: two-flop synchroniser and low-level filter for the external reset pin
// Assumes: pin active low, asynchronous to pclk
// Notes:   short low glitches never reach the output
`timescale 1ns/1ps
module rps_sync_filter
  import rps_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin and result
  input  wire logic external_reset_pin_n,
  output logic      pin_reset
);
  logic       s1_reg, s2_reg;
  logic [7:0] cnt_reg, cnt_next;
  logic       out_reg, out_next;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
    end else begin
      s1_reg <= external_reset_pin_n;
      s2_reg <= s1_reg;
    end
  end

  always_comb begin
    cnt_next = 8'h00;
    out_next = 1'b0;
    if (!s2_reg) begin
      cnt_next = (cnt_reg == 8'(PIN_FILTER_CYC)) ? cnt_reg : cnt_reg + 8'h01;
      out_next = (cnt_reg == 8'(PIN_FILTER_CYC));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign pin_reset = out_reg;
endmodule

// ### tb.sv
// Purpose: self-checking bench for the reset and start-up sequencer
// Assumes: settle shortened to SC cycles
// Notes:   apb reads are checked by a monitor from a queue of expectations
`timescale 1ns/1ps
module tb;
  import rps_pkg::*;
  localparam int unsigned SC = 50;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv, kv;
  logic        supply_rise, external_reset_pin_n, below_threshold, watchdog_timeout;
  logic        sleep_exec, irq_wake, global_irq_enable, oscillator_input;
  logic        core_reset_n, regs_reset_n, wake_pulse, external_reset_pin_oe;
  logic [15:0] start_vector;
  rps_flags_t  flags;
  rps_kind_t   reset_kind;
  logic [65:0] exp_q[$];
  logic [65:0] e;
  int          n_errors, cmp_count, cyc, seed;
  rps_sequencer #(.SETTLE_CYC(SC)) rps_sequencer_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .supply_rise, .external_reset_pin_n, .below_threshold, .watchdog_timeout,
    .sleep_exec, .irq_wake, .global_irq_enable, .oscillator_input, .core_reset_n, .regs_reset_n, .wake_pulse,
    .start_vector, .flags, .reset_kind, .external_reset_pin_oe);
  rps_far_side rps_far_side_i (.pclk, .supply_rise, .external_reset_pin_n, .below_threshold, .watchdog_timeout,
    .oscillator_input);
  always #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] ex,
                     input logic [32:0] m);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    if (!wr) exp_q.push_back({m, ex});
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] ex, input logic [32:0] m);
    apb(1'b0, a, 32'h0, ex, m);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0);
  endtask
  // counts cycles until the core runs, checked against a window
  task automatic run_within(input int lo, input int hi);
    int n;
    n = 0;
    while (core_reset_n !== 1'b1 && n <= hi) begin
      @(negedge pclk);
      n++;
    end
    chk(n >= lo && n <= hi, 1);
  endtask
  task automatic wait_wake();
    int n;
    n = 0;
    while (wake_pulse !== 1'b1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    chk(wake_pulse, 1'b1);
  endtask
  task automatic sleep_now();
    @(posedge pclk) sleep_exec <= 1'b1;
    @(posedge pclk) sleep_exec <= 1'b0;
    repeat (3) @(negedge pclk);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) chk(1, 0);
      else begin
        e = exp_q.pop_front();
        chk(({pslverr, prdata} & e[65:33]) !== (e[32:0] & e[65:33]), 0);
      end
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 60000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    sleep_exec = 0; irq_wake = 0; global_irq_enable = 0; seed = 32'h12615041;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk(core_reset_n, 0);
    chk(flags, 2'b11);
    chk(reset_kind, KIND_SUPPLY_RISE);
    rd(OFS_CFG, {29'h0, CFG_RESET}, 33'hF);
    run_within(0, SC + 10);
    rd(8'h10, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
    rv = $random(seed);
    kv = $random(seed);
    wr(OFS_SCRATCH, rv);
    wr(OFS_KEEP, kv);
    rd(OFS_SCRATCH, {1'b0, rv}, 33'h1_FFFF_FFFF);
    rps_far_side_i.wdog();
    repeat (6) @(negedge pclk);
    chk(core_reset_n, 1);
    chk(flags, 2'b01);
    chk(reset_kind, KIND_WDOG_RUN);
    rd(OFS_SCRATCH, SCRATCH_RESET, 33'h1_FFFF_FFFF);
    rd(OFS_KEEP, {1'b0, kv}, 33'h1_FFFF_FFFF);
    wr(OFS_SCRATCH, rv);
    sleep_now();
    chk(flags, 2'b10);
    rps_far_side_i.wdog();
    wait_wake();
    repeat (2) @(negedge pclk);
    chk(flags, 2'b00);
    chk(reset_kind, KIND_WDOG_WAKE);
    rd(OFS_SCRATCH, {1'b0, rv}, 33'h1_FFFF_FFFF);
    sleep_now();
    @(posedge pclk) global_irq_enable <= 1'b1;
    irq_wake <= 1'b1;
    wait_wake();
    @(posedge pclk) irq_wake <= 1'b0;
    repeat (2) @(negedge pclk);
    chk(start_vector, IRQ_VECTOR);
    rps_far_side_i.pin_low(4);
    repeat (15) @(negedge pclk);
    chk(core_reset_n, 1);
    fork
      rps_far_side_i.pin_low(3 * SC);
      begin
        repeat (SC) @(negedge pclk);
        chk(core_reset_n, 0);
        chk(reset_kind, KIND_PIN_RUN);
      end
    join
    // release: two sync flops, filter flop, then hold to run
    run_within(5, 5);
    sleep_now();
    rps_far_side_i.pin_low(30);
    chk(reset_kind, KIND_PIN_SLEEP);
    run_within(0, SC + 10);
    rps_far_side_i.dip(DIP_MIN_CYCLES / 2);
    repeat (10) @(negedge pclk);
    chk(core_reset_n, 1);
    rps_far_side_i.dip(DIP_MIN_CYCLES + 50);
    chk(core_reset_n, 0);
    chk(reset_kind, KIND_SUPPLY_DIP);
    run_within(SC, SC + 20);
    wr(OFS_CFG, 32'h1);
    rps_far_side_i.dip(DIP_MIN_CYCLES + 50);
    repeat (10) @(negedge pclk);
    chk(core_reset_n, 1);
    wr(OFS_CFG, 32'h9);
    rps_far_side_i.rise_pulse();
    repeat (3) @(negedge pclk);
    chk(core_reset_n, 0);
    chk(reset_kind, KIND_SUPPLY_RISE);
    chk(flags, 2'b11);
    // crystal at 34 ns period: 1024 rises take about 3482 clocks after settle
    run_within(SC + 3400, SC + 3600);
    complete_run();
  end
endmodule
